/* rtl/buf_readback_regs.vh */
// constants for the buffer read-back command interpreter
`ifndef BUF_READBACK_REGS_VH
`define BUF_READBACK_REGS_VH

// command block layout
`define CDB_LEN 4'hA
`define CDB_LAST 4'h9
`define CDB_OPCODE_BYTE 0
`define CDB_MODE_BYTE 1
`define CDB_ID_BYTE 2
`define CDB_OFS_BYTE 3
`define CDB_ALLOC_BYTE 6
`define CDB_CTRL_BYTE 9
`define OP_READBACK 8'h3C

// mode field codes
`define MODE_COMBINED 3'h0
`define MODE_VENDOR 3'h1
`define MODE_DATA 3'h2
`define MODE_DESC 3'h3

// reply lengths in bytes
`define HDR_LEN 24'h00_0004
`define DESC_LEN 24'h00_0004

// alignment code meaning offset zero only
`define BOUND_ZERO_ONLY 8'hFF

// completion status and sense
`define STAT_GOOD 8'h00
`define STAT_CHECK 8'h02
`define SKEY_NONE 4'h0
`define SKEY_ILLEGAL 4'h5
`define ASC_NONE 8'h00
`define ASC_BAD_OPCODE 8'h20
`define ASC_BAD_FIELD 8'h24

`endif

/* rtl/buffer_readback.v */
// target-side interpreter for the diagnostic buffer read-back command
`timescale 1ns/1ps
`include "buf_readback_regs.vh"
module buffer_readback #(
  parameter NUM_BUFS = 2,
  parameter ID_W = 1,
  parameter ADDR_W = 8,
  parameter [7:0] OFFSET_BOUND = 8'h00,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_PTR_W = 4
) (
  input wire core_clk,
  input wire rst,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [7:0] cmd_byte,
  output wire din_valid,
  input wire din_ready,
  output wire [7:0] din_data,
  output reg status_valid_r,
  output reg [7:0] status_r,
  output reg [3:0] sense_key_r,
  output reg [7:0] asc_r,
  output wire busy,
  output wire medium_wr_en,
  input wire buf_wr_en,
  input wire [ID_W-1:0] buf_wr_id,
  input wire [ADDR_W-1:0] buf_wr_addr,
  input wire [7:0] buf_wr_data
);
  // idle collects ten bytes, decode checks them once, then fetch and push
  // alternate per reply byte; the drain state holds status back until the
  // fifo is empty so that the pulse marks the true end of data-in
  localparam [2:0] S_CMD = 3'h0;
  localparam [2:0] S_DECODE = 3'h1;
  localparam [2:0] S_FETCH = 3'h2;
  localparam [2:0] S_PUSH = 3'h3;
  localparam [2:0] S_DRAIN = 3'h4;
  localparam [2:0] S_STATUS = 3'h5;

  localparam [23:0] CAP = 24'h00_0001 << ADDR_W;
  localparam [7:0] NBUF8 = NUM_BUFS[7:0];

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  wire [7:0] cdb [0:9];
  reg [3:0] idx_r;
  reg [23:0] cnt_r;
  reg [23:0] cnt_nxt;
  reg [23:0] total_r;
  reg [23:0] total_nxt;
  reg [7:0] stat_nxt;
  reg [3:0] key_nxt;
  reg [7:0] asc_nxt;
  reg [7:0] push_byte;

  wire [7:0] opcode;
  wire [2:0] mode;
  wire [7:0] buf_id;
  wire [23:0] offset;
  wire [23:0] alloc;
  wire id_ok;
  wire [23:0] align_mask;
  wire offset_ok;
  wire [23:0] rd_pos;
  wire [ID_W-1:0] rd_id;
  wire [7:0] mem_byte;
  wire fifo_ready;
  wire fifo_empty;
  wire push;
  wire [23:0] cnt_inc;
  wire take;
  wire last_push;
  wire [23:0] comb_total;
  wire [23:0] data_total;
  wire [23:0] desc_total;

  // field extraction from the stored block
  assign opcode = cdb[`CDB_OPCODE_BYTE];
  assign mode = cdb[`CDB_MODE_BYTE][2:0];
  assign buf_id = cdb[`CDB_ID_BYTE];
  assign offset = {cdb[`CDB_OFS_BYTE], cdb[`CDB_OFS_BYTE+1], cdb[`CDB_OFS_BYTE+2]};
  assign alloc = {cdb[`CDB_ALLOC_BYTE], cdb[`CDB_ALLOC_BYTE+1], cdb[`CDB_ALLOC_BYTE+2]};

  // ids run 0..NUM_BUFS-1, shared with the write port numbering
  assign id_ok = (buf_id < NBUF8);

  // the alignment mask is all ones when only offset zero is allowed
  assign align_mask = (OFFSET_BOUND == `BOUND_ZERO_ONLY) ? 24'hFF_FFFF :
    ((24'h00_0001 << OFFSET_BOUND) - 24'h00_0001);
  // an offset equal to the capacity is accepted and simply yields no data
  assign offset_ok = ((offset & align_mask) == 24'h00_0000) && (offset <= CAP);

  // combined mode reads buffer zero after the header; data mode reads from offset
  assign rd_pos = (mode == `MODE_COMBINED) ? (cnt_r - `HDR_LEN) : (offset + cnt_r);
  assign rd_id = (mode == `MODE_COMBINED) ? {ID_W{1'b0}} : buf_id[ID_W-1:0];

  assign cmd_ready = (state_r == S_CMD);
  assign busy = (state_r != S_CMD);
  assign push = (state_r == S_PUSH) & fifo_ready;
  assign cnt_inc = cnt_r + 24'h00_0001;
  assign take = cmd_valid & cmd_ready;
  assign last_push = (cnt_inc == total_r);

  // this block only reads buffers; it never requests a medium write
  assign medium_wr_en = 1'b0;

  function [23:0] min24;
    input [23:0] a;
    input [23:0] b;
    begin
      min24 = (a < b) ? a : b;
    end
  endfunction

  // reply lengths per mode, each capped by the allocation length
  assign comb_total = min24(alloc, CAP + `HDR_LEN);
  assign data_total = min24(alloc, CAP - offset);
  assign desc_total = min24(alloc, `DESC_LEN);

  // the write port stays open during a reply; a host that writes a buffer
  // while reading it back sees a mix of old and new bytes
  buffer_store #(
    .ID_W(ID_W),
    .ADDR_W(ADDR_W)
  ) u_store (
    .core_clk(core_clk),
    .wr_en(buf_wr_en),
    .wr_id(buf_wr_id),
    .wr_addr(buf_wr_addr),
    .wr_data(buf_wr_data),
    .rd_id(rd_id),
    .rd_addr(rd_pos[ADDR_W-1:0]),
    .rd_data(mem_byte)
  );

  // the fifo lets the two-cycle fetch run ahead of a stalling initiator
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .PTR_W(FIFO_PTR_W)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(state_r == S_PUSH),
    .in_ready(fifo_ready),
    .in_data(push_byte),
    .out_valid(din_valid),
    .out_ready(din_ready),
    .out_data(din_data),
    .empty(fifo_empty)
  );

  // reply byte for the current count
  always @* begin
    push_byte = mem_byte;
    case (mode)
      `MODE_COMBINED: begin
        if (cnt_r < `HDR_LEN) begin
          case (cnt_r[1:0])
            2'h0: push_byte = 8'h00;
            2'h1: push_byte = CAP[23:16];
            2'h2: push_byte = CAP[15:8];
            default: push_byte = CAP[7:0];
          endcase
        end
      end
      `MODE_DESC: begin
        if (!id_ok) begin
          push_byte = 8'h00;
        end else begin
          case (cnt_r[1:0])
            2'h0: push_byte = OFFSET_BOUND;
            2'h1: push_byte = CAP[23:16];
            2'h2: push_byte = CAP[15:8];
            default: push_byte = CAP[7:0];
          endcase
        end
      end
      default: begin
        push_byte = mem_byte;
      end
    endcase
  end

  // sequencing and command decode
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    total_nxt = total_r;
    stat_nxt = status_r;
    key_nxt = sense_key_r;
    asc_nxt = asc_r;
    case (state_r)
      S_CMD: begin
        if (cmd_valid && idx_r == `CDB_LAST) begin
          state_nxt = S_DECODE;
        end
      end
      S_DECODE: begin
        cnt_nxt = 24'h00_0000;
        total_nxt = 24'h00_0000;
        stat_nxt = `STAT_GOOD;
        key_nxt = `SKEY_NONE;
        asc_nxt = `ASC_NONE;
        state_nxt = S_FETCH;
        if (opcode != `OP_READBACK) begin
          stat_nxt = `STAT_CHECK;
          key_nxt = `SKEY_ILLEGAL;
          asc_nxt = `ASC_BAD_OPCODE;
          state_nxt = S_STATUS;
        end else begin
          case (mode)
            `MODE_COMBINED: begin
              // id and offset are ignored here
              total_nxt = comb_total;
            end
            `MODE_VENDOR, `MODE_DATA: begin
              // vendor mode is given the same meaning as data mode
              if (!id_ok) begin
                stat_nxt = `STAT_CHECK;
                key_nxt = `SKEY_ILLEGAL;
                asc_nxt = `ASC_BAD_FIELD;
                state_nxt = S_STATUS;
              end else if (!offset_ok) begin
                stat_nxt = `STAT_CHECK;
                key_nxt = `SKEY_ILLEGAL;
                asc_nxt = `ASC_BAD_FIELD;
                state_nxt = S_STATUS;
              end else begin
                total_nxt = data_total;
              end
            end
            `MODE_DESC: begin
              total_nxt = desc_total;
            end
            default: begin
              stat_nxt = `STAT_CHECK;
              key_nxt = `SKEY_ILLEGAL;
              asc_nxt = `ASC_BAD_FIELD;
              state_nxt = S_STATUS;
            end
          endcase
          // an empty reply still passes the drain state, so status timing is uniform
          if (state_nxt == S_FETCH && total_nxt == 24'h00_0000) begin
            state_nxt = S_DRAIN;
          end
        end
      end
      S_FETCH: begin
        // one cycle for the registered buffer read
        state_nxt = S_PUSH;
      end
      S_PUSH: begin
        if (push) begin
          cnt_nxt = cnt_inc;
          if (last_push) begin
            state_nxt = S_DRAIN;
          end else begin
            state_nxt = S_FETCH;
          end
        end
      end
      S_DRAIN: begin
        // status must not overtake reply bytes still queued
        if (fifo_empty) begin
          state_nxt = S_STATUS;
        end
      end
      S_STATUS: begin
        state_nxt = S_CMD;
      end
      default: begin
        state_nxt = S_CMD;
      end
    endcase
  end

  // command bytes are captured in arrival order
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idx_r <= 4'h0;
    end else if (take) begin
      idx_r <= (idx_r == `CDB_LAST) ? 4'h0 : idx_r + 4'h1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_cdb
      // one register per byte keeps each entry to a single driver
      reg [7:0] byte_r;
      assign cdb[gi] = byte_r;
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          byte_r <= 8'h00;
        end else if (take && idx_r == gi) begin
          byte_r <= cmd_byte;
        end
      end
    end
  endgenerate

  // status and sense hold from one decode to the next; the pulse alone marks completion
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= S_CMD;
      cnt_r <= 24'h00_0000;
      total_r <= 24'h00_0000;
      status_r <= `STAT_GOOD;
      sense_key_r <= `SKEY_NONE;
      asc_r <= `ASC_NONE;
      status_valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      total_r <= total_nxt;
      status_r <= stat_nxt;
      sense_key_r <= key_nxt;
      asc_r <= asc_nxt;
      status_valid_r <= (state_r == S_STATUS);
    end
  end
endmodule

/* rtl/buffer_store.v */
// diagnostic buffer memory: one write port, one registered read port
`timescale 1ns/1ps
module buffer_store #(
  parameter ID_W = 1,
  parameter ADDR_W = 8
) (
  input wire core_clk,
  input wire wr_en,
  input wire [ID_W-1:0] wr_id,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [ID_W-1:0] rd_id,
  input wire [ADDR_W-1:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] mem [0:(1<<(ID_W+ADDR_W))-1];

  // read every cycle; the caller waits one cycle after moving the address
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[{wr_id, wr_addr}] <= wr_data;
    end
    rd_data <= mem[{rd_id, rd_addr}];
  end
endmodule

/* rtl/byte_fifo.v */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter PTR_W = 4
) (
  input wire core_clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_r;
  reg [PTR_W-1:0] rd_ptr_r;
  reg [PTR_W:0] count_r;
  wire push;
  wire pop;
  localparam [PTR_W:0] FULL_CNT = DEPTH[PTR_W:0];
  localparam [PTR_W-1:0] LAST_PTR = FULL_CNT[PTR_W-1:0] - 1'b1;

  assign in_ready = (count_r != FULL_CNT);
  assign out_valid = (count_r != {(PTR_W+1){1'b0}});
  assign empty = ~out_valid;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_r];

  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= {PTR_W{1'b0}};
      rd_ptr_r <= {PTR_W{1'b0}};
      count_r <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? {PTR_W{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? {PTR_W{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

/* testbench/buffer_readback_sva.sv */
// port-level checks on the buffer read-back interpreter
`timescale 1ns/1ps
`include "buf_readback_regs.vh"
module buffer_readback_sva (
  input wire core_clk,
  input wire rst,
  input wire cmd_ready,
  input wire din_valid,
  input wire din_ready,
  input wire [7:0] din_data,
  input wire status_valid_r,
  input wire [7:0] status_r,
  input wire [3:0] sense_key_r,
  input wire [7:0] asc_r,
  input wire busy,
  input wire medium_wr_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  medium_idle_a: assert property (!medium_wr_en)
    else $error("medium written");
  data_hold_a: assert property (din_valid && !din_ready |=> din_valid && $stable(din_data))
    else $error("data byte lost");
  one_pulse_a: assert property (status_valid_r |=> !status_valid_r)
    else $error("status pulse long");
  good_sense_a: assert property (status_valid_r && status_r == `STAT_GOOD
    |-> sense_key_r == `SKEY_NONE && asc_r == `ASC_NONE) else $error("sense on good");
  check_sense_a: assert property (status_valid_r && status_r != `STAT_GOOD
    |-> status_r == `STAT_CHECK && sense_key_r == `SKEY_ILLEGAL) else $error("bad check");
  drained_first_a: assert property (status_valid_r |-> !din_valid)
    else $error("status before drain");
  no_overlap_a: assert property (din_valid |-> !cmd_ready)
    else $error("command taken during data");
  status_bound_a: assert property ($rose(busy) |-> ##[1:1000] status_valid_r)
    else $error("no status");
  idle_after_a: assert property (status_valid_r |=> cmd_ready && !busy)
    else $error("not idle after status");
  cover property (din_valid && !din_ready);
  cover property (status_valid_r && status_r == `STAT_CHECK);
  cover property (status_valid_r && status_r == `STAT_GOOD);
endmodule
bind buffer_readback buffer_readback_sva chk_u (.core_clk(core_clk), .rst(rst), .cmd_ready(cmd_ready),
  .din_valid(din_valid), .din_ready(din_ready), .din_data(din_data), .status_valid_r(status_valid_r),
  .status_r(status_r), .sense_key_r(sense_key_r), .asc_r(asc_r), .busy(busy), .medium_wr_en(medium_wr_en));

/* testbench/buffer_readback_tb.sv */
// self-checking bench for the buffer read-back interpreter
`timescale 1ns/1ps
`include "buf_readback_regs.vh"
module buffer_readback_tb;
  localparam logic [19:0] GOOD = {`STAT_GOOD, `SKEY_NONE, `ASC_NONE};
  localparam logic [19:0] BAD = {`STAT_CHECK, `SKEY_ILLEGAL, `ASC_BAD_FIELD};
  logic core_clk = 0;
  logic rst = 1;
  logic cmd_valid = 0;
  logic [7:0] cmd_byte = 8'h00;
  logic buf_wr_en = 0;
  logic [0:0] buf_wr_id = 1'b0;
  logic [7:0] buf_wr_addr = 8'h00;
  logic [7:0] buf_wr_data = 8'h00;
  logic slow = 0;
  wire din_valid, din_ready, cmd_ready, status_valid_r, busy, medium_wr_en;
  wire [7:0] din_data, status_r, asc_r;
  wire [3:0] sense_key_r;
  int bad_count = 0;
  int n_tests = 0;
  logic [7:0] exq[$];
  logic [19:0] res;
  always #50 core_clk = ~core_clk;
  buffer_readback dut_u (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_byte(cmd_byte), .din_valid(din_valid), .din_ready(din_ready), .din_data(din_data),
    .status_valid_r(status_valid_r), .status_r(status_r), .sense_key_r(sense_key_r), .asc_r(asc_r),
    .busy(busy), .medium_wr_en(medium_wr_en), .buf_wr_en(buf_wr_en), .buf_wr_id(buf_wr_id),
    .buf_wr_addr(buf_wr_addr), .buf_wr_data(buf_wr_data));
  initiator_model partner_u (.core_clk(core_clk), .rst(rst), .slow(slow), .din_valid(din_valid),
    .din_ready(din_ready), .din_data(din_data));
  function automatic logic [7:0] pat(input logic id, input logic [7:0] a);
    return id ? ~a : a ^ 8'h5A;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // sends one command block, waits for the status pulse, keeps status and sense
  task automatic issue(input logic [7:0] op, input logic [2:0] md, input logic [7:0] id,
                       input logic [23:0] ofs, input logic [23:0] al);
    logic [7:0] b[10];
    b = '{op, {5'h00, md}, id, ofs[23:16], ofs[15:8], ofs[7:0], al[23:16], al[15:8], al[7:0], 8'h00};
    partner_u.got.delete();
    foreach (b[i]) begin
      cmd_valid <= 1'b1;
      cmd_byte <= b[i];
      @(posedge core_clk);
    end
    cmd_valid <= 1'b0;
    res = 20'hx_xxxx;
    repeat (3000) begin
      @(negedge core_clk);
      if (status_valid_r === 1'b1) break;
    end
    if (status_valid_r === 1'b1) res = {status_r, sense_key_r, asc_r};
    @(posedge core_clk);
  endtask
  task automatic cmp(input logic [19:0] st);
    chk(partner_u.got.size(), exq.size());
    foreach (exq[i]) chk(partner_u.got[i], exq[i]);
    chk(res, st);
  endtask
  task automatic t_combined;
    exq = '{8'h00, 8'h00, 8'h01, 8'h00};
    for (int i = 0; i < 256; i++) exq.push_back(pat(1'b0, i[7:0]));
    issue(`OP_READBACK, `MODE_COMBINED, 8'h01, 24'h00_0005, 24'h00_0200);
    cmp(GOOD);
    exq = exq[0:39];
    slow <= 1'b1;
    issue(`OP_READBACK, `MODE_COMBINED, 8'h00, 24'h00_0000, 24'h00_0028);
    slow <= 1'b0;
    cmp(GOOD);
  endtask
  task automatic t_data;
    exq = {};
    for (int i = 250; i < 256; i++) exq.push_back(pat(1'b1, i[7:0]));
    issue(`OP_READBACK, `MODE_DATA, 8'h01, 24'h00_00FA, 24'h00_0064);
    cmp(GOOD);
    exq = '{pat(1'b0, 8'h10), pat(1'b0, 8'h11)};
    issue(`OP_READBACK, `MODE_VENDOR, 8'h00, 24'h00_0010, 24'h00_0002);
    cmp(GOOD);
  endtask
  task automatic t_desc;
    exq = '{8'h00, 8'h00, 8'h01};
    issue(`OP_READBACK, `MODE_DESC, 8'h00, 24'h00_0033, 24'h00_0003);
    cmp(GOOD);
    exq.push_back(8'h00);
    issue(`OP_READBACK, `MODE_DESC, 8'h01, 24'h00_0000, 24'h00_0004);
    cmp(GOOD);
    exq = '{8'h00, 8'h00, 8'h00, 8'h00};
    issue(`OP_READBACK, `MODE_DESC, 8'h07, 24'h00_0000, 24'h00_0008);
    cmp(GOOD);
  endtask
  task automatic t_errors;
    exq = {};
    issue(`OP_READBACK, `MODE_DATA, 8'h02, 24'h00_0000, 24'h00_0004);
    cmp(BAD);
    issue(`OP_READBACK, `MODE_DATA, 8'h00, 24'h00_0101, 24'h00_0004);
    cmp(BAD);
    for (int m = 4; m < 8; m++) begin
      issue(`OP_READBACK, m[2:0], 8'h00, 24'h00_0000, 24'h00_0004);
      cmp(BAD);
    end
    issue(8'h3B, `MODE_DATA, 8'h00, 24'h00_0000, 24'h00_0004);
    cmp({`STAT_CHECK, `SKEY_ILLEGAL, `ASC_BAD_OPCODE});
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 512; i++) begin
      buf_wr_en <= 1'b1;
      {buf_wr_id, buf_wr_addr} <= i[8:0];
      buf_wr_data <= pat(i[8], i[7:0]);
      @(posedge core_clk);
    end
    buf_wr_en <= 1'b0;
    @(posedge core_clk);
    t_combined;
    t_data;
    t_desc;
    t_errors;
    complete_run;
  end
  initial begin
    #2_000_000;
    bad_count++;
    complete_run;
  end
endmodule

/* testbench/initiator_model.sv */
// initiator side of the data-in stream: sinks bytes, can stall
`timescale 1ns/1ps
module initiator_model (
  input wire core_clk,
  input wire rst,
  input wire slow,
  input wire din_valid,
  output logic din_ready,
  input wire [7:0] din_data
);
  logic [7:0] got[$];
  logic [2:0] cnt_r;
  // slow takes one byte in eight, slower than the push rate, so the fifo fills
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 3'h0;
      din_ready <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      din_ready <= !slow || cnt_r == 3'h7;
      if (din_valid && din_ready) got.push_back(din_data);
    end
  end
endmodule
